//--- hw/dbg_ack.sv
// Acknowledge handshake and abort logic of the single-wire debug pin.
// Assumes a command decoder reporting each command end and an executor
// reporting completion; the pin is open drain with an external pull-up.
//
// Protocol rules served by this block and by its host
// (R1) Executed command: 16 ticks low, speedup, release
// (R2) Acknowledge no sooner than 32 ticks after end
// (R3) Command end is 16th tick of last bit
// (R4) Host assumes no maximum acknowledge delay
// (R5) Host reads data or sends next command
// (R6) Wait/stop before hardware command: drop it
// (R7) Acknowledge starts with target falling edge
// (R8) Host never nests commands awaiting acknowledge
// (R9) Host abort: 128 ticks low, speedup
// (R10) Long low: reference response, cancel everything
// (R11) Firmware access in progress completes, acknowledge suppressed
// (R12) Resume and step still run when aborted
// (R13) Host short abort lasts 4 to 127 ticks
// (R14) Host edge while pending cancels, no response
// (R15) Next falling edge after abort starts command
// (R16) Host uses short abort only for non-reads
// (R17) Host may size abort near 128 ticks
// (R18) Host byte read: opcode, address, wait, data
// (R19) Read acknowledged only after data captured
// (R20) Host picks byte by address parity
// (R21) Enable and disable commands; enable acknowledged
// (R22) Handshake disabled after reset
// (R23) Bits are 16 ticks, MSB first
// (R24) Response: wait 16, 128 low, speedup
// (R25) Pin synchronised; low length counted in ticks
// (R26) Host times out waits with long abort
`timescale 1ns/1ns
`default_nettype none

`include "dbg_defines.svh"

module dbg_ack #(
	parameter int TICK_DIV = `DBG_TICK_DIV
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic debug_pin_in,
	output logic debug_pin_out,
	output logic debug_pin_oe,
	input wire logic cmd_end,
	input wire dbg_pkg::dbg_cmd_s cmd_info,
	input wire logic exec_done,
	input wire logic fw_busy,
	input wire logic cpu_wait_stop,
	output logic ack_enabled,
	output logic cmd_pending,
	output logic exec_cancel,
	output logic rx_restart,
	output logic sync_busy
);

	import dbg_pkg::*;

	generate
		if (TICK_DIV < 2) begin : g_bad
			$error("dbg_ack: TICK_DIV must be at least 2");
		end
	endgenerate

	// ************************************************************
	// Serial clock and pin sampling
	// ************************************************************
	logic tick;
	logic pin_s;

	// (R23) serial clock, bit timing base
	dbg_tick #(
		.DIV(TICK_DIV)
	) u_tick (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.tick(tick)
	);

	// (R25) pin synchronised first
	dbg_sync u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.din(debug_pin_in),
		.dout(pin_s)
	);

	// ************************************************************
	// State
	// ************************************************************
	dbg_state_e st, next_st;
	dbg_cmd_s cmd, next_cmd;
	logic [7:0] cnt, next_cnt;
	logic [5:0] since_end, next_since_end;
	logic [7:0] lo_cnt, next_lo_cnt;
	logic [7:0] drv_lo, next_drv_lo;
	logic pin_d, done, next_done, next_ack_en, next_pend;
	logic next_out, next_oe, next_cancel, next_restart, next_sync;
	logic host_low, host_fall, long_hit, in_sync, gap_ok;

	// Host activity seen only while the target is not driving
	always_comb begin
		host_low = !pin_s && !debug_pin_oe;
		host_fall = pin_d && host_low;
		in_sync = (st == st_sy_rise) || (st == st_sy_gap) || (st == st_sy_lo) || (st == st_sy_hi);
		long_hit = tick && host_low && (lo_cnt == 8'(`DBG_SYNC_MIN_LO - 1)) && !in_sync;
		gap_ok = (since_end >= 6'(`DBG_ACK_MIN_GAP));
	end

	// Host low-pulse length, saturating
	always_comb begin
		next_lo_cnt = lo_cnt;
		if (!host_low) begin
			next_lo_cnt = 8'h00;
		// (R25) ticks count the low time
		end else if (tick && (lo_cnt != 8'(`DBG_SYNC_MIN_LO))) begin
			next_lo_cnt = lo_cnt + 8'h01;
		end
		next_drv_lo = (debug_pin_oe && !debug_pin_out) ? (drv_lo + 8'(tick)) : 8'h00;
	end

	// Handshake sequencer
	always_comb begin
		next_st = st;
		next_cmd = cmd;
		next_cnt = cnt;
		next_since_end = since_end;
		next_done = done;
		next_ack_en = ack_enabled;
		next_pend = cmd_pending;
		next_out = debug_pin_out;
		next_oe = debug_pin_oe;
		next_cancel = 1'b0;
		next_restart = 1'b0;
		unique case (st)
			st_idle: begin
				// (R3) end marked at 16th tick of last bit
				if (cmd_end) begin
					next_cmd = cmd_info;
					next_since_end = 6'h00;
					next_done = exec_done;
					// (R21) enable, disable commands
					if (cmd_info.ack_off) begin
						next_ack_en = 1'b0;
					end else if (cmd_info.ack_on) begin
						next_ack_en = 1'b1;
						next_done = 1'b1;
						next_pend = 1'b1;
						next_st = st_wait;
					// (R22) no pulses while disabled
					end else if (ack_enabled) begin
						next_pend = 1'b1;
						next_st = st_wait;
					end
				end
			end
			st_wait: begin
				// (R19) executor reports after data captured
				if (exec_done) begin
					next_done = 1'b1;
				end
				if (tick && !gap_ok) begin
					next_since_end = since_end + 6'h01;
				end
				// (R6) wait or stop drops the command
				if (cpu_wait_stop && !done && !exec_done && cmd.hw) begin
					next_pend = 1'b0;
					next_cancel = 1'b1;
					next_st = st_idle;
				// (R14) short abort, no reference response
				end else if (host_fall) begin
					next_pend = 1'b0;
					next_done = 1'b0;
					// (R11) (R12) running access or resume continues
					next_cancel = !done && !cmd.ctrl && !fw_busy;
					// (R15) next edge starts a command
					next_restart = 1'b1;
					next_st = st_idle;
				// (R2) (R7) own falling edge after least gap
				end else if (done && gap_ok && tick && pin_s) begin
					next_out = 1'b0;
					next_oe = 1'b1;
					next_cnt = 8'h00;
					next_st = st_ack_lo;
				end
			end
			st_ack_lo: begin
				// (R1) low for 16 ticks, then speedup
				if (tick) begin
					next_cnt = cnt + 8'h01;
					if (cnt == 8'(`DBG_ACK_LO_TICKS - 1)) begin
						next_out = 1'b1;
						next_st = st_ack_hi;
					end
				end
			end
			st_ack_hi: begin
				// (R1) speedup for one tick, then release
				if (tick) begin
					next_oe = 1'b0;
					next_pend = 1'b0;
					next_done = 1'b0;
					next_st = st_idle;
				end
			end
			st_sy_rise: begin
				// (R24) wait for the pin to return high
				if (pin_s) begin
					next_cnt = 8'h00;
					next_st = st_sy_gap;
				end
			end
			st_sy_gap: begin
				if (tick) begin
					next_cnt = cnt + 8'h01;
					if (cnt == 8'(`DBG_SYNC_GAP - 1)) begin
						next_cnt = 8'h00;
						next_out = 1'b0;
						next_oe = 1'b1;
						next_st = st_sy_lo;
					end
				end
			end
			st_sy_lo: begin
				// (R24) reference low for 128 ticks
				if (tick) begin
					next_cnt = cnt + 8'h01;
					if (cnt == 8'(`DBG_SYNC_LO - 1)) begin
						next_out = 1'b1;
						next_st = st_sy_hi;
					end
				end
			end
			st_sy_hi: begin
				// (R15) response over, receiver restarts
				if (tick) begin
					next_oe = 1'b0;
					next_restart = 1'b1;
					next_st = st_idle;
				end
			end
		endcase
		// (R10) long low cancels command and acknowledge
		if (long_hit) begin
			next_pend = 1'b0;
			next_done = 1'b0;
			next_oe = 1'b0;
			// (R11) (R12) running access or resume continues
			next_cancel = cmd_pending && !done && !cmd.ctrl && !fw_busy;
			next_st = st_sy_rise;
		end
		next_sync = (next_st == st_sy_rise) || (next_st == st_sy_gap) ||
			(next_st == st_sy_lo) || (next_st == st_sy_hi);
	end

	// State registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= st_idle;
			cmd <= '0;
			cnt <= 8'h00;
			since_end <= 6'h00;
			lo_cnt <= 8'h00;
			drv_lo <= 8'h00;
			pin_d <= 1'b1;
			done <= 1'b0;
			ack_enabled <= 1'b0;
			cmd_pending <= 1'b0;
			debug_pin_out <= 1'b1;
			debug_pin_oe <= 1'b0;
			exec_cancel <= 1'b0;
			rx_restart <= 1'b0;
			sync_busy <= 1'b0;
		end else begin
			st <= next_st;
			cmd <= next_cmd;
			cnt <= next_cnt;
			since_end <= next_since_end;
			lo_cnt <= next_lo_cnt;
			drv_lo <= next_drv_lo;
			pin_d <= pin_s;
			done <= next_done;
			ack_enabled <= next_ack_en;
			cmd_pending <= next_pend;
			debug_pin_out <= next_out;
			debug_pin_oe <= next_oe;
			exec_cancel <= next_cancel;
			rx_restart <= next_restart;
			sync_busy <= next_sync;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	ack_low_len_a: assert property ($rose(st == st_ack_hi) |-> drv_lo == 8'd16) // (R1)
		else $error("acknowledge low not 16 ticks");
	ack_release_a: assert property (st == st_ack_hi && tick |=> !debug_pin_oe) // (R1)
		else $error("acknowledge speedup not released");
	ack_gap_a: assert property ($rose(st == st_ack_lo) |-> since_end >= 6'd32) // (R2)
		else $error("acknowledge too soon after command end");
	ack_edge_a: assert property ($rose(st == st_ack_lo) |-> $past(pin_s) && !debug_pin_out) // (R7)
		else $error("acknowledge without own falling edge");
	drop_wait_a: assert property (st == st_wait && cpu_wait_stop && !done && !exec_done && cmd.hw
		|=> !cmd_pending ##1 !debug_pin_oe) // (R6)
		else $error("command kept after wait or stop");
	short_abort_a: assert property (host_fall && st == st_wait && !(cpu_wait_stop && cmd.hw && !done)
		|=> st == st_idle && !cmd_pending && rx_restart) // (R14)
		else $error("short abort not honoured");
	long_abort_a: assert property (long_hit |=> st == st_sy_rise && !cmd_pending && sync_busy) // (R10)
		else $error("long low not taken as abort");
	sync_low_len_a: assert property ($rose(st == st_sy_hi) |-> drv_lo == 8'd128) // (R24)
		else $error("reference low not 128 ticks");
	resume_kept_a: assert property (long_hit && cmd.ctrl |=> !exec_cancel) // (R12)
		else $error("resume command cancelled");
	ack_off_a: assert property (st == st_idle && cmd_end && cmd_info.ack_off
		|=> !ack_enabled && !cmd_pending) // (R21)
		else $error("handshake not disabled");
	no_ack_off_a: assert property (!ack_enabled && !(st == st_idle && cmd_end && cmd_info.ack_on)
		&& st == st_idle |=> !(st == st_wait)) // (R22)
		else $error("acknowledge armed while disabled");

endmodule : dbg_ack

`default_nettype wire

//--- hw/dbg_defines.svh
// Timing counts of the debug-pin acknowledge logic.
// Assumes one system clock; the serial clock is a divided enable.
`ifndef DBG_DEFINES_SVH
`define DBG_DEFINES_SVH

// ************************************************************
// Serial clock
// ************************************************************
`define DBG_TICK_DIV 5
`define DBG_BIT_TICKS 16

// ************************************************************
// Acknowledge pulse, in serial clock ticks
// ************************************************************
`define DBG_ACK_LO_TICKS 16
`define DBG_ACK_MIN_GAP 32

// ************************************************************
// Long low pulse and reference response, in serial clock ticks
// ************************************************************
`define DBG_SYNC_MIN_LO 128
`define DBG_SYNC_GAP 16
`define DBG_SYNC_LO 128

`endif

//--- hw/dbg_pkg.sv
// Types shared by the debug-pin acknowledge logic.
// Assumes the timing counts come from dbg_defines.svh.
`default_nettype none

package dbg_pkg;

	// ************************************************************
	// Handshake states, one-hot
	// ************************************************************
	typedef enum logic [7:0] {
		st_idle = 8'h01,
		st_wait = 8'h02,
		st_ack_lo = 8'h04,
		st_ack_hi = 8'h08,
		st_sy_rise = 8'h10,
		st_sy_gap = 8'h20,
		st_sy_lo = 8'h40,
		st_sy_hi = 8'h80
	} dbg_state_e;

	// ************************************************************
	// Kind of the command that has just ended
	// ************************************************************
	typedef struct packed {
		logic ack_on;   // Handshake-enable command
		logic ack_off;  // Handshake-disable command
		logic hw;       // Hardware command
		logic fw_rw;    // Firmware read or write
		logic ctrl;     // Resume, resume-until-halt, single_step_command
	} dbg_cmd_s;

endpackage : dbg_pkg

`default_nettype wire

//--- hw/dbg_tick.sv
// Serial clock enable: one-cycle pulse every DIV system clocks.
// Assumes a free-running system clock and asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module dbg_tick #(
	parameter int DIV = 5
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	output logic tick
);

	localparam int W = (DIV > 2) ? $clog2(DIV) : 1;

	// ************************************************************
	// Divider
	// ************************************************************
	generate
		if (DIV < 2) begin : g_bad
			$error("dbg_tick: DIV must be at least 2");
		end
	endgenerate

	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic next_tick;

	// Wrap counter and raise the enable on wrap
	always_comb begin
		next_tick = (cnt == W'(DIV - 1));
		next_cnt = next_tick ? '0 : cnt + W'(1);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end

endmodule : dbg_tick

`default_nettype wire

//--- hw/dbg_sync.sv
// Two-flop synchroniser for the debug pin input level.
// Assumes the pin idles high through its pull-up.
`timescale 1ns/1ns
`default_nettype none

module dbg_sync (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);

	logic meta;

	// ************************************************************
	// Synchroniser chain, only the second flop is read
	// ************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 1'b1;
			dout <= 1'b1;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end

endmodule : dbg_sync

`default_nettype wire

//--- tb/dbg_pod.sv
// Debug probe model: drives host low pulses on request and times target lows.
// Assumes the bench resolves the open-drain pin with a pull-up.
`timescale 1ns/1ns
`default_nettype none

module dbg_pod #(
	parameter int D = 5
) (
	input wire logic ref_clk,
	input wire logic pin,
	input wire logic go,
	input wire logic [9:0] lo_ticks,
	output var logic h_oe = 1'b0,
	output var logic h_out = 1'b1,
	output var logic busy = 1'b0,
	output var int ack_n = 0,
	output var int lo_len = 0
);
	// Idle with the pin released
	int n = 0;
	int run = 0;

	always @(posedge ref_clk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			h_oe <= 1'b1;
			h_out <= 1'b0;
			n <= lo_ticks * D + D;
		end else if (busy) begin
			n <= n - 1;
			if (n == D + 1)
				h_out <= 1'b1; // One tick of speedup
			if (n == 1) begin
				h_oe <= 1'b0;
				busy <= 1'b0;
			end
		end
	end

	// Length of each low driven by the target, in clocks
	// data or next command only after release
	always @(posedge ref_clk) begin
		if (!pin && !h_oe) begin
			run <= run + 1;
		end else if (run != 0) begin
			lo_len <= run;
			ack_n <= ack_n + 1;
			run <= 0;
		end
	end
endmodule : dbg_pod

`default_nettype wire

//--- tb/dbg_ack_tb.sv
// Self-checking bench for the debug-pin acknowledge logic.
// Assumes dbg_pod stands for the debug probe on the open-drain pin.
`timescale 1ns/1ns
`default_nettype none

module dbg_ack_tb;
	import dbg_pkg::*;

	localparam int D = 5;
	localparam dbg_cmd_s c_on = 5'h10, c_off = 5'h08, c_hw = 5'h04, c_fw = 5'h02, c_ctl = 5'h01;

	typedef struct packed {
		dbg_cmd_s info;
		logic pend;
		logic en;
	} dbg_row_s;

	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_end = 1'b0;
	logic exec_done = 1'b0;
	logic fw_busy = 1'b0;
	logic cpu_wait_stop = 1'b0;
	logic go = 1'b0;
	logic [9:0] lo_ticks = 10'h000;
	dbg_cmd_s cmd_info = 5'h00;
	logic pin_out, pin_oe, ack_enabled, cmd_pending, exec_cancel, rx_restart, sync_busy, h_oe, h_out, pbusy;
	int cancel_n = 0, restart_n = 0, sync_n = 0;
	int ack_n, lo_len, k, n0;
	int fail_count = 0;
	int comparisons = 0;
	wire logic pin = !((pin_oe && !pin_out) || (h_oe && !h_out));
	dbg_row_s rows [7] = '{'{c_hw, 1'b0, 1'b0}, '{c_on, 1'b1, 1'b1}, '{c_hw, 1'b1, 1'b1},
		'{c_fw, 1'b1, 1'b1}, '{c_ctl, 1'b1, 1'b1}, '{c_off, 1'b0, 1'b0}, '{c_hw, 1'b0, 1'b0}};

	always #20 ref_clk = ~ref_clk;

	dbg_ack #(.TICK_DIV(D)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .debug_pin_in(pin), .debug_pin_out(pin_out),
		.debug_pin_oe(pin_oe), .cmd_end(cmd_end), .cmd_info(cmd_info), .exec_done(exec_done), .fw_busy(fw_busy),
		.cpu_wait_stop(cpu_wait_stop), .ack_enabled(ack_enabled), .cmd_pending(cmd_pending),
		.exec_cancel(exec_cancel), .rx_restart(rx_restart), .sync_busy(sync_busy));

	dbg_pod #(.D(D)) pod (.ref_clk(ref_clk), .pin(pin), .go(go), .lo_ticks(lo_ticks), .h_oe(h_oe),
		.h_out(h_out), .busy(pbusy), .ack_n(ack_n), .lo_len(lo_len));

	// Catch one-cycle status pulses and count sync_busy cycles
	always @(posedge ref_clk) begin
		if (exec_cancel) cancel_n <= cancel_n + 1;
		if (rx_restart) restart_n <= restart_n + 1;
		if (sync_busy) sync_n <= sync_n + 1;
	end

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	// One command end, optionally already executed
	task automatic send(input dbg_cmd_s info, input logic done);
		@(posedge ref_clk);
		cmd_end <= 1'b1;
		cmd_info <= info;
		exec_done <= done;
		@(posedge ref_clk);
		cmd_end <= 1'b0;
		exec_done <= 1'b0;
	endtask : send

	// Executed command, then pulse timing and handshake state
	task automatic run(input dbg_cmd_s info, input logic pend, input logic en);
		n0 = ack_n;
		send(info, 1'b1);
		#1 check(cmd_pending, pend);
		k = 1;
		while (k < 40 * D && pin_oe !== 1'b1) begin
			@(posedge ref_clk);
			#1;
			k = k + 1;
		end
		if (pend) check((k >= 32 * D) && (k <= 34 * D), 1'b1);
		for (k = 0; k < 40 * D && cmd_pending !== 1'b0; k++) begin
			@(posedge ref_clk);
			#1;
		end
		#1 check(ack_n - n0, pend);
		if (pend) check(lo_len, 16 * D);
		check(ack_enabled, en);
	endtask : run

	// Unexecuted command ended by wait/stop or by a host low pulse
	task automatic abort_case(input dbg_cmd_s info, input logic fwb, input logic ws, input logic [9:0] lo,
		input logic ec);
		int c0, r0, s0;
		n0 = ack_n;
		c0 = cancel_n;
		r0 = restart_n;
		s0 = sync_n;
		send(info, 1'b0);
		fw_busy <= fwb;
		cpu_wait_stop <= ws;
		if (lo != 10'h000) begin
			lo_ticks <= lo;
			go <= 1'b1;
			@(posedge ref_clk);
			go <= 1'b0;
		end
		#1;
		for (k = 0; k < 400 * D && (cmd_pending || sync_busy || pbusy) !== 1'b0; k++) begin
			@(posedge ref_clk);
			#1;
		end
		repeat (4) @(posedge ref_clk);
		#1 check(cmd_pending, 1'b0);
		check(cancel_n != c0, ec);
		if (lo != 10'h000) check(restart_n != r0, 1'b1);
		check(sync_n != s0, lo > 127);
		check(ack_n - n0, lo > 127);
		if (lo > 127) check(lo_len, 128 * D);
		@(posedge ref_clk);
		fw_busy <= 1'b0;
		cpu_wait_stop <= 1'b0;
	endtask : abort_case

	// ************************************************************
	// Sequence
	// ************************************************************
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		foreach (rows[i]) run(rows[i].info, rows[i].pend, rows[i].en);
		run(c_on, 1'b1, 1'b1);
		n0 = ack_n;
		send(c_fw, 1'b0);
		repeat (200) @(posedge ref_clk);
		#1 check(cmd_pending & !pin_oe & (ack_n == n0), 1'b1);
		@(posedge ref_clk);
		exec_done <= 1'b1;
		@(posedge ref_clk);
		exec_done <= 1'b0;
		for (k = 0; k < 40 * D && cmd_pending !== 1'b0; k++) begin
			@(posedge ref_clk);
			#1;
		end
		#1 check(ack_n - n0, 1);
		abort_case(c_hw, 1'b0, 1'b1, 10'h000, 1'b1);
		// short abort only on non-read commands
		abort_case(c_hw, 1'b0, 1'b0, 10'h006, 1'b1);
		abort_case(c_ctl, 1'b0, 1'b0, 10'h006, 1'b0);
		abort_case(c_fw, 1'b1, 1'b0, 10'h082, 1'b0);
		abort_case(c_hw, 1'b0, 1'b0, 10'h082, 1'b1);
		abort_case(c_ctl, 1'b0, 1'b0, 10'h082, 1'b0);
		run(c_hw, 1'b1, 1'b1);
		send(c_hw, 1'b0);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1 check(ack_enabled | cmd_pending | pin_oe, 1'b0);
		run(c_hw, 1'b0, 1'b0);
		give_verdict();
	end

	// Watchdog well past the expected run length
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		give_verdict();
	end
endmodule : dbg_ack_tb

`default_nettype wire
